// [src/power_mode_pkg.sv]
package power_mode_pkg;
   // Avalon-MM register map, byte addresses of aligned 32-bit words
   localparam int ADDR_W = 5;
   localparam logic [ADDR_W-1:0] OFS_SYS_CTRL1 = 5'h00;
   localparam logic [ADDR_W-1:0] OFS_SYS_CTRL2 = 5'h04;
   localparam logic [ADDR_W-1:0] OFS_INT_ENABLE1 = 5'h08;
   localparam logic [ADDR_W-1:0] OFS_MODULE_STBY = 5'h0c;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;

   // system_control_reg1 fields
   localparam int SC1_STANDBY_BIT = 0;
   localparam int SC1_SETTLE_LSB = 4;
   localparam int SETTLE_SEL_W = 3;
   // system_control_reg2 fields
   localparam int SC2_ACT_LSB = 0;
   localparam int ACT_SEL_W = 3;
   localparam int SC2_SUB_LSB = 3;
   localparam int SUB_SEL_W = 2;
   localparam int SC2_DTE_BIT = 5;
   localparam int SC2_LOW_SPEED_ON_FLAG_BIT = 6;
   // interrupt enable register 1
   localparam int IE1_DT_BIT = 0;
   // status register fields
   localparam int ST_MODE_LSB = 0;
   localparam int ST_SEQ_LSB = 4;
   localparam int ST_ACT_LSB = 8;
   localparam int ST_SUB_LSB = 12;
   localparam int ST_NOWAKE_BIT = 16;

   localparam logic [7:0] SC1_RESET = 8'h00;
   localparam logic [7:0] SC2_RESET = 8'h00;
   localparam logic [31:0] DATA_ZERO = 32'h0000_0000;

   // Transition state counts, in CPU states
   localparam int SLEEP_EXEC_STATES = 2;
   localparam int INTERNAL_STATES = 1;
   localparam int EXCEPTION_STATES = 14;
   localparam int CNT_W = 16;
   localparam logic [CNT_W-1:0] PRE_COUNT = CNT_W'(SLEEP_EXEC_STATES + INTERNAL_STATES);
   localparam logic [CNT_W-1:0] EXC_COUNT = CNT_W'(EXCEPTION_STATES);

   // Subactive divider ratios of the watch clock
   localparam logic [3:0] SUB_DIV2 = 4'h2;
   localparam logic [3:0] SUB_DIV4 = 4'h4;
   localparam logic [3:0] SUB_DIV8 = 4'h8;
   localparam int SYS_DIV_W = 8;

   typedef enum logic [2:0] {MODE_ACTIVE, MODE_SUBACTIVE, MODE_SLEEP, MODE_SUBSLEEP, MODE_STANDBY} mode_t;
   typedef enum logic [2:0] {SQ_RUN, SQ_PRE, SQ_SETTLE, SQ_EXC, SQ_DOWN} seq_t;
endpackage

// [src/clk_ctl_if.sv]
`timescale 1ns/100ps
interface clk_ctl_if;
   import power_mode_pkg::*;
   logic sysRun;
   logic subRun;
   logic [ACT_SEL_W-1:0] actSel;
   logic [SUB_SEL_W-1:0] subSel;
   logic watchTick;
   logic cpuTick;
   logic sysTick;
   modport ctrl (output sysRun, output subRun, output actSel, output subSel, output watchTick,
                 input cpuTick, input sysTick);
   modport gen (input sysRun, input subRun, input actSel, input subSel, input watchTick,
                output cpuTick, output sysTick);
endinterface

// [src/cpu_clk_gen.sv]
`timescale 1ns/100ps
module cpu_clk_gen
   import power_mode_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic rst_n, // Asynchronous reset, active low
   clk_ctl_if.gen ctl // Clock selection and ticks
);
   logic [SYS_DIV_W-1:0] sysCnt;
   logic [3:0] subCnt;
   logic [3:0] subDiv;
   logic sysHit;

   // Divide ratio is a power of two: the counter's low bits all ones marks a tick
   assign sysHit = (sysCnt & SYS_DIV_W'((1 << ctl.actSel) - 1)) == SYS_DIV_W'((1 << ctl.actSel) - 1);

   always_comb
   begin
      case (ctl.subSel)
         2'h0: subDiv = SUB_DIV2;
         2'h1: subDiv = SUB_DIV4;
         default: subDiv = SUB_DIV8;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         sysCnt <= '0;
      else if (!ctl.sysRun || sysHit)
         sysCnt <= '0;
      else
         sysCnt <= sysCnt + SYS_DIV_W'(1);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         subCnt <= '0;
      else if (!ctl.subRun)
         subCnt <= '0;
      else if (ctl.watchTick)
         subCnt <= (subCnt + 4'h1 >= subDiv) ? 4'h0 : subCnt + 4'h1;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         ctl.sysTick <= 1'b0;
         ctl.cpuTick <= 1'b0;
      end
      else
      begin
         ctl.sysTick <= ctl.sysRun && sysHit;
         ctl.cpuTick <= (ctl.sysRun && sysHit) ||
                        (ctl.subRun && ctl.watchTick && (subCnt + 4'h1 >= subDiv));
      end
   end
endmodule // cpu_clk_gen

// [src/direct_mode_transition_ctrl.sv]
// Design decisions made here: register access over Avalon-MM and the register offsets.
`timescale 1ns/100ps
module direct_mode_transition_ctrl
   import power_mode_pkg::*;
#(
   parameter int NUM_MODULES = 8,
   parameter int SETTLE_BASE_STATES = 8192
)
(
   input wire logic ref_clk, // 20 MHz clock
   input wire logic rst_n, // Asynchronous reset, active low
   input wire logic [power_mode_pkg::ADDR_W-1:0] address, // Avalon byte address
   input wire logic read, // Avalon read
   input wire logic write, // Avalon write
   input wire logic [3:0] byteenable, // Avalon byte enables
   input wire logic [31:0] writedata, // Avalon write data
   output logic [31:0] readdata, // Avalon read data
   output logic waitrequest, // Avalon wait request
   input wire logic sleepExec, // CPU sleep instruction pulse
   input wire logic intMaskBit, // Condition code register interrupt mask
   input wire logic wakeIrq, // Enabled interrupt request level
   input wire logic watchClkPin, // Watch clock from pin
   output logic cpuClkEn, // CPU state enable pulse
   output logic cpuHalt, // CPU halted in a power-down mode or the settle wait
   output logic dtIrq, // Direct transition exception in progress
   output logic [NUM_MODULES-1:0] periphClkEn // Per-module clock enables
);
   import power_mode_pkg::*;

   clk_ctl_if ctl ();

   logic [7:0] sysCtrl1;
   logic [7:0] sysCtrl2;
   logic dtIntEnable;
   logic [NUM_MODULES-1:0] moduleStby;
   logic [CNT_W-1:0] stateCnt;
   logic [ACT_SEL_W-1:0] appliedAct;
   logic [SUB_SEL_W-1:0] appliedSub;
   logic noWake;
   logic excAfter;
   logic fromSub;
   logic wSync1;
   logic wSync2;
   logic wSync3;
   mode_t mode;
   seq_t seq;
   logic busGo;
   logic [31:0] regValue;
   logic directOk;
   logic targetSub;
   logic wakeOk;
   logic tickStale;

   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] wd, input logic be);
      merge8 = be ? wd[7:0] : old;
   endfunction

   // Settle wait halves with each step of the select field
   function automatic logic [CNT_W-1:0] settleStates(input logic [SETTLE_SEL_W-1:0] sel);
      settleStates = CNT_W'(SETTLE_BASE_STATES >> sel);
   endfunction

   // Bus slave: one wait cycle, write commits on the edge that sees waitrequest low
   assign busGo = (read || write) && !waitrequest;

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         waitrequest <= 1'b1;
      else
         waitrequest <= !((read || write) && waitrequest);
   end

   always_comb
   begin
      regValue = DATA_ZERO;
      case (address)
         OFS_SYS_CTRL1: regValue[7:0] = sysCtrl1;
         OFS_SYS_CTRL2: regValue[7:0] = sysCtrl2;
         OFS_INT_ENABLE1: regValue[IE1_DT_BIT] = dtIntEnable;
         OFS_MODULE_STBY: regValue[NUM_MODULES-1:0] = moduleStby;
         OFS_STATUS:
         begin
            regValue[ST_MODE_LSB +: 3] = mode;
            regValue[ST_SEQ_LSB +: 3] = seq;
            regValue[ST_ACT_LSB +: ACT_SEL_W] = appliedAct;
            regValue[ST_SUB_LSB +: SUB_SEL_W] = appliedSub;
            regValue[ST_NOWAKE_BIT] = noWake;
         end
         default: regValue = DATA_ZERO;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         readdata <= DATA_ZERO;
      else if (read && waitrequest)
         readdata <= regValue;
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sysCtrl1 <= SC1_RESET;
         sysCtrl2 <= SC2_RESET;
         dtIntEnable <= 1'b0;
         moduleStby <= '0;
      end
      else if (busGo && write)
      begin
         case (address)
            OFS_SYS_CTRL1: sysCtrl1 <= merge8(sysCtrl1, writedata, byteenable[0]);
            // Frequency fields only land here; the clock picks them up at the next sleep
            OFS_SYS_CTRL2: sysCtrl2 <= merge8(sysCtrl2, writedata, byteenable[0]);
            OFS_INT_ENABLE1:
            begin
               if (byteenable[0])
                  dtIntEnable <= writedata[IE1_DT_BIT];
            end
            OFS_MODULE_STBY:
            begin
               for (int i = 0; i < NUM_MODULES; i++)
                  if (byteenable[i / 8])
                     moduleStby[i] <= writedata[i];
            end
            default: ;
         endcase
      end
   end

   // Watch clock crosses in from its pin; only the second stage onward is looked at
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         wSync1 <= 1'b0;
         wSync2 <= 1'b0;
         wSync3 <= 1'b0;
      end
      else
      begin
         wSync1 <= watchClkPin;
         wSync2 <= wSync1;
         wSync3 <= wSync2;
      end
   end

   assign ctl.watchTick = wSync2 && !wSync3;
   assign ctl.actSel = appliedAct;
   assign ctl.subSel = appliedSub;
   // System clock runs in active, sleep and the settle wait; standby and subsleep stop it
   assign ctl.sysRun = (mode == MODE_ACTIVE) || (mode == MODE_SLEEP);
   assign ctl.subRun = (mode == MODE_SUBACTIVE) || (mode == MODE_SUBSLEEP);

   cpu_clk_gen clkGen (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .ctl(ctl)
   );

   assign directOk = sysCtrl2[SC2_DTE_BIT] && dtIntEnable && !intMaskBit;
   assign targetSub = sysCtrl2[SC2_LOW_SPEED_ON_FLAG_BIT];
   assign wakeOk = wakeIrq && !noWake;

   // The tick in flight when the clock source switches still belongs to the old clock
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
         tickStale <= 1'b0;
      else
         tickStale <= ((seq == SQ_PRE) && ctl.cpuTick && (stateCnt + CNT_W'(1) >= PRE_COUNT)) ||
                      ((seq == SQ_DOWN) && wakeOk);
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         seq <= SQ_RUN;
         mode <= MODE_ACTIVE;
         stateCnt <= '0;
         appliedAct <= '0;
         appliedSub <= '0;
         noWake <= 1'b0;
         excAfter <= 1'b0;
         fromSub <= 1'b0;
      end
      else
      begin
         case (seq)
            SQ_RUN:
            begin
               if (sleepExec && directOk)
               begin
                  seq <= SQ_PRE;
                  stateCnt <= '0;
                  fromSub <= (mode == MODE_SUBACTIVE);
               end
               else if (sleepExec)
               begin
                  // Ordinary power-down choice, also the fallback of a refused direct attempt
                  seq <= SQ_DOWN;
                  noWake <= sysCtrl2[SC2_DTE_BIT] && intMaskBit;
                  fromSub <= (mode == MODE_SUBACTIVE);
                  if (sysCtrl1[SC1_STANDBY_BIT] && mode == MODE_ACTIVE)
                     mode <= MODE_STANDBY;
                  else if (mode == MODE_SUBACTIVE)
                     mode <= MODE_SUBSLEEP;
                  else
                     mode <= MODE_SLEEP;
               end
            end
            SQ_PRE:
            begin
               // Sleep and internal states are counted on the old clock
               if (ctl.cpuTick)
               begin
                  if (stateCnt + CNT_W'(1) >= PRE_COUNT)
                  begin
                     stateCnt <= '0;
                     appliedAct <= sysCtrl2[SC2_ACT_LSB +: ACT_SEL_W];
                     appliedSub <= sysCtrl2[SC2_SUB_LSB +: SUB_SEL_W];
                     mode <= targetSub ? MODE_SUBACTIVE : MODE_ACTIVE;
                     excAfter <= 1'b1;
                     seq <= (fromSub && !targetSub) ? SQ_SETTLE : SQ_EXC;
                  end
                  else
                     stateCnt <= stateCnt + CNT_W'(1);
               end
            end
            SQ_SETTLE:
            begin
               // Oscillator settling, counted in new system clock states
               if (ctl.sysTick && !tickStale)
               begin
                  if (stateCnt + CNT_W'(1) >= settleStates(sysCtrl1[SC1_SETTLE_LSB +: SETTLE_SEL_W]))
                  begin
                     stateCnt <= '0;
                     seq <= excAfter ? SQ_EXC : SQ_RUN;
                  end
                  else
                     stateCnt <= stateCnt + CNT_W'(1);
               end
            end
            SQ_EXC:
            begin
               // Exception states on the post-transition clock
               if (ctl.cpuTick && !tickStale)
               begin
                  if (stateCnt + CNT_W'(1) >= EXC_COUNT)
                  begin
                     stateCnt <= '0;
                     excAfter <= 1'b0;
                     seq <= SQ_RUN;
                  end
                  else
                     stateCnt <= stateCnt + CNT_W'(1);
               end
            end
            SQ_DOWN:
            begin
               // A masked direct attempt leaves only reset as the way out
               if (wakeOk)
               begin
                  appliedAct <= sysCtrl2[SC2_ACT_LSB +: ACT_SEL_W];
                  appliedSub <= sysCtrl2[SC2_SUB_LSB +: SUB_SEL_W];
                  mode <= targetSub ? MODE_SUBACTIVE : MODE_ACTIVE;
                  stateCnt <= '0;
                  excAfter <= 1'b0;
                  seq <= (!targetSub && (mode != MODE_SLEEP)) ? SQ_SETTLE : SQ_RUN;
               end
            end
            default: seq <= SQ_RUN;
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         cpuClkEn <= 1'b0;
         cpuHalt <= 1'b0;
         dtIrq <= 1'b0;
         periphClkEn <= '0;
      end
      else
      begin
         // CPU keeps running through a direct transition outside its settle wait; held only in power-down and settle
         cpuClkEn <= ctl.cpuTick && !tickStale && (seq != SQ_DOWN) && (seq != SQ_SETTLE);
         cpuHalt <= (seq == SQ_DOWN) || (seq == SQ_SETTLE);
         dtIrq <= (seq == SQ_EXC);
         periphClkEn <= ~moduleStby & {NUM_MODULES{mode != MODE_STANDBY}};
      end
   end
endmodule // direct_mode_transition_ctrl

// [dv/direct_mode_transition_ctrl_props.sv]
`timescale 1ns/100ps
module direct_mode_transition_ctrl_props
   import power_mode_pkg::*;
#(
   parameter int NUM_MODULES = 8
)
(
   input wire logic ref_clk, // Clock
   input wire logic rst_n, // Reset
   input wire logic [power_mode_pkg::ADDR_W-1:0] address, // Bus address
   input wire logic read, // Bus read
   input wire logic write, // Bus write
   input wire logic [3:0] byteenable, // Lanes
   input wire logic [31:0] writedata, // Write data
   input wire logic [31:0] readdata, // Read data
   input wire logic waitrequest, // Bus wait
   input wire logic sleepExec, // Sleep pulse
   input wire logic intMaskBit, // Mask
   input wire logic wakeIrq, // Wake request
   input wire logic watchClkPin, // Watch clock
   input wire logic cpuClkEn, // CPU state
   input wire logic cpuHalt, // Halted
   input wire logic dtIrq, // Exception
   input wire logic [NUM_MODULES-1:0] periphClkEn // Module clocks
);
   logic [4:0] dtCnt;
   logic stbyWr;
   assign stbyWr = write && !waitrequest && address == OFS_MODULE_STBY;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   // Counts CPU states inside the exception window so its length is exact
   always_ff @(posedge ref_clk or negedge rst_n)
      if (!rst_n)
         dtCnt <= 5'h00;
      else if (!dtIrq)
         dtCnt <= 5'h00;
      else if (cpuClkEn)
         dtCnt <= dtCnt + 5'h01;

   property p_ack;
      (read || write) && waitrequest |=> !waitrequest;
   endproperty
   a_ack: assert property (p_ack) else $error("bus request not answered");
   property p_one;
      !waitrequest |=> waitrequest;
   endproperty
   a_one: assert property (p_one) else $error("wait low too long");
   property p_rd_hold;
      !read |=> $stable(readdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_dt_count;
      $fell(dtIrq) |-> dtCnt == 5'h0e;
   endproperty
   a_dt_count: assert property (p_dt_count) else $error("exception length wrong");
   property p_dt_hold;
      $rose(dtIrq) |-> dtIrq [*8];
   endproperty
   a_dt_hold: assert property (p_dt_hold) else $error("exception cut short");
   property p_excl;
      !(cpuHalt && dtIrq);
   endproperty
   a_excl: assert property (p_excl) else $error("halted during exception");
   property p_sleep;
      sleepExec && !cpuHalt && !dtIrq |-> ##[1:1000] (cpuHalt || dtIrq);
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep had no effect");
   // Module clocks may move only after a standby write, reset or a power-down
   property p_pclk;
      $changed(periphClkEn) |-> $past(stbyWr) || $past(stbyWr, 2) || !$past(rst_n, 2) || cpuHalt || $past(cpuHalt);
   endproperty
   a_pclk: assert property (p_pclk) else $error("module clocks moved");
   c_dt: cover property ($fell(dtIrq));
   c_halt: cover property ($rose(cpuHalt));
   c_wake: cover property ($fell(cpuHalt) && !dtIrq);
endmodule // direct_mode_transition_ctrl_props

bind direct_mode_transition_ctrl direct_mode_transition_ctrl_props #(.NUM_MODULES(NUM_MODULES)) props_i (.ref_clk,
   .rst_n, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .sleepExec, .intMaskBit,
   .wakeIrq, .watchClkPin, .cpuClkEn, .cpuHalt, .dtIrq, .periphClkEn);

// [dv/direct_mode_transition_ctrl_tb.sv]
`timescale 1ns/100ps
module direct_mode_transition_ctrl_tb;
   import power_mode_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [ADDR_W-1:0] address = 5'h00;
   logic read = 1'b0, write = 1'b0, sleepExec = 1'b0, intMaskBit = 1'b0, wakeIrq = 1'b0, watchClkPin = 1'b0;
   logic [3:0] byteenable = 4'hf;
   logic [31:0] writedata = 32'h0, readdata, q;
   logic waitrequest, cpuClkEn, cpuHalt, dtIrq;
   logic [7:0] periphClkEn;
   int mismatches = 0, tests_run = 0, n, h;

   always #25 ref_clk = ~ref_clk;
   // Watch clock unrelated to ref_clk; each phase spans four ref_clk cycles for the synchroniser
   always #200 watchClkPin = ~watchClkPin;

   direct_mode_transition_ctrl #(.NUM_MODULES(8), .SETTLE_BASE_STATES(16)) uut (.ref_clk, .rst_n, .address,
      .read, .write, .byteenable, .writedata, .readdata, .waitrequest, .sleepExec, .intMaskBit, .wakeIrq,
      .watchClkPin, .cpuClkEn, .cpuHalt, .dtIrq, .periphClkEn);

   task final_report;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
      tests_run++;
      if (s !== e)
      begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, e, s);
      end
   endtask
   task bus(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      address <= a;
      write <= w;
      read <= ~w;
      writedata <= d;
      @(posedge ref_clk);
      while (waitrequest !== 1'b0)
         @(posedge ref_clk);
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
   endtask
   task rd_mode(input logic [2:0] m);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("mode", 32'(m), 32'(q[2:0]));
   endtask
   task ticks(input int c);
      n = 0;
      repeat (c)
      begin
         @(posedge ref_clk);
         n += (cpuClkEn === 1'b1) ? 1 : 0;
      end
   endtask
   task slp;
      @(posedge ref_clk);
      sleepExec <= 1'b1;
      @(posedge ref_clk);
      sleepExec <= 1'b0;
   endtask
   task wait_halt(input logic v);
      int k;
      k = 0;
      while (cpuHalt !== v && k < 5000)
      begin
         @(posedge ref_clk);
         k++;
      end
      chk("halt", 32'(v), 32'(cpuHalt));
   endtask
   // Counts halted cycles before the exception and CPU states inside it
   task wait_dt;
      int k;
      k = 0;
      n = 0;
      h = 0;
      while (dtIrq !== 1'b1 && k < 5000)
      begin
         @(posedge ref_clk);
         k++;
         h += (cpuHalt === 1'b1) ? 1 : 0;
      end
      while (dtIrq === 1'b1)
      begin
         n += (cpuClkEn === 1'b1) ? 1 : 0;
         @(posedge ref_clk);
      end
   endtask
   task gap;
      n = 1;
      while (cpuClkEn !== 1'b1)
         @(posedge ref_clk);
      @(posedge ref_clk);
      while (cpuClkEn !== 1'b1)
      begin
         n++;
         @(posedge ref_clk);
      end
   endtask
   task reset_dut;
      rst_n <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_n <= 1'b1;
   endtask

   task t_reset;
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("status", 32'h0, q);
      bus(1'b0, 5'h14, 32'h0);
      chk("unmapped", 32'h0, q);
      ticks(16);
      chk("act clk", 32'h10, 32'(n));
      chk("pclk", 32'hff, 32'(periphClkEn));
   endtask
   task t_standby;
      bus(1'b1, OFS_MODULE_STBY, 32'ha5);
      ticks(2);
      chk("pclk", 32'h5a, 32'(periphClkEn));
      bus(1'b0, OFS_MODULE_STBY, 32'h0);
      chk("stby", 32'ha5, q);
      bus(1'b1, OFS_MODULE_STBY, 32'h0);
      ticks(2);
      chk("pclk", 32'hff, 32'(periphClkEn));
   endtask
   task t_to_sub;
      bus(1'b1, OFS_SYS_CTRL2, 32'h71);
      bus(1'b1, OFS_INT_ENABLE1, 32'h1);
      ticks(16);
      chk("old clk", 32'h10, 32'(n));
      slp;
      wait_dt;
      chk("exc", 32'h0e, 32'(n));
      chk("halted", 32'h0, 32'(h));
      rd_mode(3'h1);
      gap;
      chk("sub div", 32'h40, 32'(n));
   endtask
   task t_to_act;
      bus(1'b1, OFS_SYS_CTRL2, 32'h21);
      slp;
      wait_dt;
      chk("exc", 32'h0e, 32'(n));
      chk("settle", 32'h1, 32'(h > 0));
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("act sel", 32'h1, 32'(q[10:8]));
      chk("mode", 32'h0, 32'(q[2:0]));
      ticks(16);
      chk("new clk", 32'h8, 32'(n));
   endtask
   task t_sleep;
      bus(1'b1, OFS_INT_ENABLE1, 32'h0);
      slp;
      wait_halt(1'b1);
      rd_mode(3'h2);
      wakeIrq <= 1'b1;
      wait_halt(1'b0);
      wakeIrq <= 1'b0;
      rd_mode(3'h0);
   endtask
   task t_masked;
      bus(1'b1, OFS_INT_ENABLE1, 32'h1);
      intMaskBit <= 1'b1;
      slp;
      wait_halt(1'b1);
      bus(1'b0, OFS_STATUS, 32'h0);
      chk("no wake", 32'h1, 32'(q[16]));
      wakeIrq <= 1'b1;
      ticks(40);
      chk("stuck", 32'h1, 32'(cpuHalt));
      wakeIrq <= 1'b0;
      intMaskBit <= 1'b0;
      reset_dut;
   endtask
   task t_plain;
      bus(1'b1, OFS_SYS_CTRL2, 32'h40);
      slp;
      wait_halt(1'b1);
      rd_mode(3'h2);
      wakeIrq <= 1'b1;
      wait_halt(1'b0);
      wakeIrq <= 1'b0;
      rd_mode(3'h1);
   endtask
   // Subsleep and standby, both left through the shortened settle wait
   task t_deep_sleep;
      bus(1'b1, OFS_SYS_CTRL1, 32'h11);
      bus(1'b1, OFS_SYS_CTRL2, 32'h00);
      slp;
      wait_halt(1'b1);
      rd_mode(3'h3);
      wakeIrq <= 1'b1;
      wait_halt(1'b0);
      wakeIrq <= 1'b0;
      rd_mode(3'h0);
      slp;
      wait_halt(1'b1);
      rd_mode(3'h4);
      chk("stby pclk", 32'h0, 32'(periphClkEn));
      wakeIrq <= 1'b1;
      wait_halt(1'b0);
      wakeIrq <= 1'b0;
      rd_mode(3'h0);
      chk("pclk", 32'hff, 32'(periphClkEn));
   endtask

   initial
   begin
      reset_dut;
      t_reset;
      t_standby;
      t_to_sub;
      t_to_act;
      t_sleep;
      t_masked;
      t_plain;
      t_deep_sleep;
      final_report;
   end
   // The full sequence needs well under 10000 cycles
   initial
   begin
      repeat (30000) @(posedge ref_clk);
      mismatches++;
      final_report;
   end
endmodule // direct_mode_transition_ctrl_tb
